//--- comparator_pkg.sv
package comparator_pkg;

  localparam int          NUM_CHAN         = 3;
  localparam int          ADDR_W           = 8;

  // register byte offsets
  localparam logic [7:0]  OFS_MASKED_STAT  = 8'h00;
  localparam logic [7:0]  OFS_RAW_STAT     = 8'h04;
  localparam logic [7:0]  OFS_INT_ENABLE   = 8'h08;
  localparam logic [7:0]  OFS_REF_CTRL     = 8'h10;
  localparam logic [7:0]  OFS_CHAN_STATUS  = 8'h20;
  localparam logic [7:0]  OFS_CHAN_CTRL    = 8'h24;
  localparam logic [7:0]  CHAN_STRIDE      = 8'h20;

  // control word field positions
  localparam int          POS_INT_SENSE    = 2;
  localparam int          POS_INT_LEVEL    = 4;
  localparam int          POS_TRIG_SENSE   = 5;
  localparam int          POS_TRIG_LEVEL   = 7;
  localparam int          POS_TRIG_EN      = 8;
  localparam int          POS_SRC_SEL      = 9;
  localparam int          POS_OUT_EN       = 11;
  localparam int          POS_RESULT       = 1;
  localparam int          POS_REF_TAP      = 0;
  localparam int          POS_REF_RANGE    = 8;
  localparam int          POS_REF_EN       = 9;

  // reset values
  localparam logic [2:0]  RST_INT_ENABLE   = 3'h0;
  localparam logic [2:0]  RST_RAW_STAT     = 3'h0;
  localparam logic [31:0] RST_CTRL_WORD    = 32'h0000_0000;
  localparam logic [31:0] RST_REF_WORD     = 32'h0000_0000;

  // edge sense encodings
  localparam logic [1:0]  SENSE_LEVEL      = 2'h0;
  localparam logic [1:0]  SENSE_FALL       = 2'h1;
  localparam logic [1:0]  SENSE_RISE       = 2'h2;
  localparam logic [1:0]  SENSE_BOTH       = 2'h3;

  // source select encodings
  localparam logic [1:0]  SRC_OWN_PIN      = 2'h0;
  localparam logic [1:0]  SRC_ALT_PIN      = 2'h1;
  localparam logic [1:0]  SRC_REFERENCE    = 2'h2;

  // reference ladder figures
  localparam logic [4:0]  LADDER_OFFSET    = 5'h08;
  localparam logic [4:0]  LADDER_DEN_LOW   = 5'h1F;
  localparam logic [4:0]  LADDER_DEN_HIGH  = 5'h17;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {
    ROUTE_OWN_PIN,
    ROUTE_CHAN0_PIN,
    ROUTE_REFERENCE,
    ROUTE_OPEN
  } route_type;

  typedef struct packed {
    logic       out_en;
    logic [1:0] src_sel;
    logic       trig_en;
    logic       trig_level;
    logic [1:0] trig_sense;
    logic       int_level;
    logic [1:0] int_sense;
  } chan_cfg_type;

  typedef struct packed {
    logic       enable;
    logic       range;
    logic [3:0] tap;
  } ref_cfg_type;

  typedef struct packed {
    logic       enable;
    logic       range;
    logic [3:0] tap;
    logic [4:0] numerator;
    logic [4:0] denominator;
  } ladder_drive_type;

  function automatic logic sense_hit(input logic [1:0] sense,
                                     input logic       level,
                                     input logic       prev,
                                     input logic       cur);
    logic hit;
    hit = 1'b0;
    unique case (sense)
      SENSE_LEVEL: hit = (cur == level);
      SENSE_FALL:  hit = prev & ~cur;
      SENSE_RISE:  hit = ~prev & cur;
      SENSE_BOTH:  hit = prev ^ cur;
    endcase
    return hit;
  endfunction

endpackage

//--- comparator_channel.sv
`timescale 1ns/1ps
module comparator_channel
  import comparator_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         raw_async,
  input  chan_cfg_type      cfg,
  output logic              result,
  output logic              int_event,
  output logic              trig_event
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q,  prev_d;
  logic int_q,   int_d;
  logic trig_q,  trig_d;

  always_comb begin
    sync1_d = raw_async;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    // interrupt and trigger judged separately on the same result
    int_d   = sense_hit(cfg.int_sense, cfg.int_level, prev_q, sync2_q);
    trig_d  = cfg.trig_en & sense_hit(cfg.trig_sense, cfg.trig_level, prev_q, sync2_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      int_q   <= 1'b0;
      trig_q  <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      int_q   <= int_d;
      trig_q  <= trig_d;
    end
  end

  assign result     = prev_q;
  assign int_event  = int_q;
  assign trig_event = trig_q;

endmodule // comparator_channel

//--- comparator_control.sv
// What this block does
// - three independent channels, each with pin output, interrupt and ADC trigger.
// - result is 1 when inverting input is below noninverting, else 0.
// - interrupt and ADC trigger edge selections are independent per channel.
// - inverting input always comes from the channel's own negative pin.
// - channel 0 select 00 or 01 routes its own positive pin, 10 reference.
// - channels 1, 2: 00 own pin, 01 channel 0 pin, 10 reference.
// - shared pin on channels 1, 2 is output or positive input, never both.
// - reference disabled gives ground regardless of tap value.
// - enabled, range 0: reference is supply times (tap plus 8) over 31.
// - enabled, range 1: reference is supply times tap over 23.
// - masked status, raw status and enable registers, one bit per channel.
// - raw status bit sets on an interrupt condition and is read-only.
// - writing 1 to a masked status bit clears the pending interrupt.
`timescale 1ns/1ps
module comparator_control
  import comparator_pkg::*;
#(
  parameter int N_CHAN = NUM_CHAN
)(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [N_CHAN-1:0]    raw_result,
  output route_type [N_CHAN-1:0]    vin_plus_route,
  output route_type [N_CHAN-1:0]    vin_minus_route,
  output ladder_drive_type          ladder_drive,
  output logic [N_CHAN-1:0]         pin_out,
  output logic [N_CHAN-1:0]         pin_oe,
  output logic [N_CHAN-1:0]         adc_trigger,
  output logic                      irq
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic chan_cfg_type cfg_from_word(input logic [31:0] w);
    chan_cfg_type c;
    c.int_sense  = w[POS_INT_SENSE +: 2];
    c.int_level  = w[POS_INT_LEVEL];
    c.trig_sense = w[POS_TRIG_SENSE +: 2];
    c.trig_level = w[POS_TRIG_LEVEL];
    c.trig_en    = w[POS_TRIG_EN];
    c.src_sel    = w[POS_SRC_SEL +: 2];
    c.out_en     = w[POS_OUT_EN];
    return c;
  endfunction

  function automatic logic [31:0] cfg_to_word(input chan_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_INT_SENSE +: 2]  = c.int_sense;
    w[POS_INT_LEVEL]       = c.int_level;
    w[POS_TRIG_SENSE +: 2] = c.trig_sense;
    w[POS_TRIG_LEVEL]      = c.trig_level;
    w[POS_TRIG_EN]         = c.trig_en;
    w[POS_SRC_SEL +: 2]    = c.src_sel;
    w[POS_OUT_EN]          = c.out_en;
    return w;
  endfunction

  // channel index of a per-channel offset, or N_CHAN when none matches
  function automatic int chan_of(input logic [ADDR_W-1:0] a, input logic [7:0] base);
    int hit;
    hit = N_CHAN;
    for (int i = 0; i < N_CHAN; i++) begin
      if (a == ADDR_W'(base + CHAN_STRIDE * i)) begin
        hit = i;
      end
    end
    return hit;
  endfunction

  // register state
  logic [N_CHAN-1:0]           raw_q, raw_d;
  logic [N_CHAN-1:0]           inten_q, inten_d;
  ref_cfg_type                 ref_q, ref_d;
  chan_cfg_type [N_CHAN-1:0]   ctl_q, ctl_d;

  // bus state
  logic                        aw_held_q, aw_held_d;
  logic [ADDR_W-1:0]           awaddr_q, awaddr_d;
  logic                        w_held_q, w_held_d;
  logic [31:0]                 wdata_q, wdata_d;
  logic [3:0]                  wstrb_q, wstrb_d;
  logic                        bvalid_q, bvalid_d;
  logic [1:0]                  bresp_q, bresp_d;
  logic                        rvalid_q, rvalid_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic [1:0]                  rresp_q, rresp_d;

  logic [N_CHAN-1:0]           result;
  logic [N_CHAN-1:0]           int_event;
  logic [N_CHAN-1:0]           trig_event;
  logic [N_CHAN-1:0]           masked;
  logic [N_CHAN-1:0]           clr_mask;
  logic                        do_write;
  logic                        do_read;

  for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
    comparator_channel u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .raw_async  (raw_result[g]),
      .cfg        (ctl_q[g]),
      .result     (result[g]),
      .int_event  (int_event[g]),
      .trig_event (trig_event[g])
    );
  end

  assign masked   = raw_q & inten_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign do_read  = s_axi_arvalid & s_axi_arready;

  // register file and interrupt status
  always_comb begin
    logic [31:0] word;
    int          ch;
    word     = 32'h0000_0000;
    ch       = N_CHAN;
    raw_d    = raw_q;
    inten_d  = inten_q;
    ref_d    = ref_q;
    ctl_d    = ctl_q;
    clr_mask = '0;
    bresp_d  = bresp_q;
    if (do_write) begin
      bresp_d = RESP_OKAY;
      ch      = chan_of(awaddr_q, OFS_CHAN_CTRL);
      if (awaddr_q == ADDR_W'(OFS_MASKED_STAT)) begin
        word     = merge_strb(32'h0000_0000, wdata_q, wstrb_q);
        clr_mask = word[N_CHAN-1:0];
      end else if (awaddr_q == ADDR_W'(OFS_INT_ENABLE)) begin
        word    = merge_strb({{(32-N_CHAN){1'b0}}, inten_q}, wdata_q, wstrb_q);
        inten_d = word[N_CHAN-1:0];
      end else if (awaddr_q == ADDR_W'(OFS_REF_CTRL)) begin
        word         = {22'h0, ref_q.enable, ref_q.range, 4'h0, ref_q.tap};
        word         = merge_strb(word, wdata_q, wstrb_q);
        ref_d.tap    = word[POS_REF_TAP +: 4];
        ref_d.range  = word[POS_REF_RANGE];
        ref_d.enable = word[POS_REF_EN];
      end else if (ch < N_CHAN) begin
        word      = merge_strb(cfg_to_word(ctl_q[ch]), wdata_q, wstrb_q);
        ctl_d[ch] = cfg_from_word(word);
      end else if (awaddr_q == ADDR_W'(OFS_RAW_STAT) ||
                   chan_of(awaddr_q, OFS_CHAN_STATUS) < N_CHAN) begin
        // read-only registers ignore the write
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end
    // a new event beats a clear in the same cycle
    raw_d = (raw_q & ~clr_mask) | int_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q   <= RST_RAW_STAT;
      inten_q <= RST_INT_ENABLE;
      ref_q   <= '0;
      for (int i = 0; i < N_CHAN; i++) begin
        ctl_q[i] <= cfg_from_word(RST_CTRL_WORD);
      end
      bresp_q <= RESP_OKAY;
    end else begin
      raw_q   <= raw_d;
      inten_q <= inten_d;
      ref_q   <= ref_d;
      ctl_q   <= ctl_d;
      bresp_q <= bresp_d;
    end
  end

  // write channel handshake: address and data taken in either order
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
      w_held_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
      w_held_q  <= w_held_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
    end
  end

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // read path; answer one cycle after the address is taken
  always_comb begin
    int cs;
    int cc;
    cs       = chan_of(s_axi_araddr, OFS_CHAN_STATUS);
    cc       = chan_of(s_axi_araddr, OFS_CHAN_CTRL);
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (do_read) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      rresp_d  = RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(OFS_MASKED_STAT)) begin
        rdata_d[N_CHAN-1:0] = masked;
      end else if (s_axi_araddr == ADDR_W'(OFS_RAW_STAT)) begin
        rdata_d[N_CHAN-1:0] = raw_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_INT_ENABLE)) begin
        rdata_d[N_CHAN-1:0] = inten_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_REF_CTRL)) begin
        rdata_d[POS_REF_TAP +: 4] = ref_q.tap;
        rdata_d[POS_REF_RANGE]    = ref_q.range;
        rdata_d[POS_REF_EN]       = ref_q.enable;
      end else if (cs < N_CHAN) begin
        rdata_d[POS_RESULT] = result[cs];
      end else if (cc < N_CHAN) begin
        rdata_d = cfg_to_word(ctl_q[cc]);
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // analog steering: input routing, pins, ladder
  always_comb begin
    for (int i = 0; i < N_CHAN; i++) begin
      vin_minus_route[i] = ROUTE_OWN_PIN;
      unique case (ctl_q[i].src_sel)
        SRC_OWN_PIN:   vin_plus_route[i] = ROUTE_OWN_PIN;
        // channel 0 has no alternate, its own pin is the alternate
        SRC_ALT_PIN:   vin_plus_route[i] = (i == 0) ? ROUTE_OWN_PIN
                                                    : ROUTE_CHAN0_PIN;
        SRC_REFERENCE: vin_plus_route[i] = ROUTE_REFERENCE;
        default:       vin_plus_route[i] = ROUTE_OPEN;
      endcase
      pin_out[i] = result[i];
      // shared pin cannot drive while it feeds the positive input
      pin_oe[i]  = ctl_q[i].out_en &
                   ((i == 0) || (ctl_q[i].src_sel != SRC_OWN_PIN));
    end
  end

  always_comb begin
    ladder_drive.enable = ref_q.enable;
    if (!ref_q.enable) begin
      // quietest ground: range 1, tap 0
      ladder_drive.range       = 1'b1;
      ladder_drive.tap         = 4'h0;
      ladder_drive.numerator   = 5'h00;
      ladder_drive.denominator = LADDER_DEN_HIGH;
    end else if (!ref_q.range) begin
      ladder_drive.range       = 1'b0;
      ladder_drive.tap         = ref_q.tap;
      ladder_drive.numerator   = 5'(ref_q.tap) + LADDER_OFFSET;
      ladder_drive.denominator = LADDER_DEN_LOW;
    end else begin
      ladder_drive.range       = 1'b1;
      ladder_drive.tap         = ref_q.tap;
      ladder_drive.numerator   = 5'(ref_q.tap);
      ladder_drive.denominator = LADDER_DEN_HIGH;
    end
  end

  assign adc_trigger = trig_event;
  assign irq         = |masked;

endmodule // comparator_control

//--- comparator_monitor.sv
`timescale 1ns/1ps
module comparator_monitor
  import comparator_pkg::*;
#(
  parameter int N_CHAN = NUM_CHAN
)(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire logic [N_CHAN-1:0]      raw_result,
  input wire route_type [N_CHAN-1:0] vin_plus_route,
  input wire route_type [N_CHAN-1:0] vin_minus_route,
  input wire ladder_drive_type       ladder_drive,
  input wire logic [N_CHAN-1:0]      pin_out,
  input wire logic [N_CHAN-1:0]      pin_oe,
  input wire logic [N_CHAN-1:0]      adc_trigger,
  input wire logic                   irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // own pin encodes as zero in every slot
  minus_own_a: assert property (vin_minus_route == '0)
    else $error("inverting input not on own pin");
  chan0_alt_a: assert property (vin_plus_route[0] != ROUTE_CHAN0_PIN)
    else $error("channel 0 routed to alternate pin");
  shared_pin_a: assert property (!(pin_oe[1] && vin_plus_route[1] == ROUTE_OWN_PIN)
    && !(pin_oe[2] && vin_plus_route[2] == ROUTE_OWN_PIN))
    else $error("shared pin both driven and sensed");
  ladder_off_a: assert property (!ladder_drive.enable |->
    ladder_drive.range && ladder_drive.tap == 4'h0) else $error("ladder off not quiet");
  ladder_low_a: assert property (ladder_drive.enable && !ladder_drive.range |->
    ladder_drive.numerator == {1'b0, ladder_drive.tap} + 5'h08
    && ladder_drive.denominator == 5'h1F) else $error("low range ratio wrong");
  ladder_high_a: assert property (ladder_drive.enable && ladder_drive.range |->
    ladder_drive.numerator == {1'b0, ladder_drive.tap}
    && ladder_drive.denominator == 5'h17) else $error("high range ratio wrong");
  // sync chain plus result flop needs about three edges
  result_pin_a: assert property ($stable(raw_result) [*6] |-> pin_out == raw_result)
    else $error("pin output does not follow result");
  irq_reset_a: assert property ($rose(aresetn) |-> !irq [*2])
    else $error("interrupt high out of reset");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0000_0000) else $error("error read with data");

  cover property ($rose(irq));
  cover property (adc_trigger != '0);
  cover property (pin_oe[1]);
endmodule // comparator_monitor

//--- analog_front.sv
`timescale 1ns/1ps
module analog_front
  import comparator_pkg::*;
#(
  parameter int AVDD_MV = 3300
)(
  input wire route_type [2:0]  vin_plus_route,
  input wire route_type [2:0]  vin_minus_route,
  input wire ladder_drive_type ladder_drive,
  input wire logic [2:0]       pin_oe,
  input wire logic [15:0]      pos_mv [3],
  input wire logic [15:0]      neg_mv [3],
  output logic [2:0]           raw_result
);
  logic [15:0] ref_mv;
  logic [15:0] plus_mv;
  logic [15:0] minus_mv;

  // pads treated as analog only, digital input held off
  always_comb begin
    ref_mv = 16'h0000;
    if (ladder_drive.enable && ladder_drive.range) begin
      ref_mv = 16'(AVDD_MV * int'(ladder_drive.tap) / 32'h17);
    end else if (ladder_drive.enable) begin
      ref_mv = 16'(AVDD_MV * (int'(ladder_drive.tap) + 32'h8) / 32'h1F);
    end
    for (int i = 0; i < 3; i++) begin
      case (vin_plus_route[i])
        // a driven shared pin carries no input
        ROUTE_OWN_PIN:   plus_mv = pin_oe[i] ? 16'h0000 : pos_mv[i];
        ROUTE_CHAN0_PIN: plus_mv = pos_mv[0];
        ROUTE_REFERENCE: plus_mv = ref_mv;
        default:         plus_mv = 16'h0000;
      endcase
      minus_mv = (vin_minus_route[i] == ROUTE_OWN_PIN) ? neg_mv[i] : 16'hFFFF;
      raw_result[i] = minus_mv < plus_mv;
    end
  end
endmodule // analog_front

//--- test_comparator_control.sv
`timescale 1ns/1ps
module test_comparator_control;
  import comparator_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00;
  logic             s_axi_awvalid = 1'b0;
  logic             s_axi_awready;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'hF;
  logic             s_axi_wvalid = 1'b0;
  logic             s_axi_wready;
  logic [1:0]       s_axi_bresp;
  logic             s_axi_bvalid;
  logic             s_axi_bready = 1'b0;
  logic [7:0]       s_axi_araddr = 8'h00;
  logic             s_axi_arvalid = 1'b0;
  logic             s_axi_arready;
  logic [31:0]      s_axi_rdata;
  logic [1:0]       s_axi_rresp;
  logic             s_axi_rvalid;
  logic             s_axi_rready = 1'b0;
  logic [2:0]       raw_result;
  logic [2:0]       pin_out;
  logic [2:0]       pin_oe;
  logic [2:0]       adc_trigger;
  logic             irq;
  route_type [2:0]  vin_plus_route;
  route_type [2:0]  vin_minus_route;
  ladder_drive_type ladder_drive;
  logic [15:0]      pos_mv [3];
  logic [15:0]      neg_mv [3];
  logic [31:0]      bus_data;
  logic [1:0]       bus_resp;
  int               miscompares = 0;
  int               checks = 0;
  int               cycles = 0;
  int               trig_count = 0;

  comparator_control comparator_control_i (.*);
  analog_front analog_front_i (.*);

  initial begin
    forever #5 aclk = ~aclk;
  end

  always @(negedge aclk) begin
    cycles++;
    if (adc_trigger[0] === 1'b1) trig_count++;
    if (cycles == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bvalid;
      bus_resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_hit, r_hit;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rvalid;
      bus_data = s_axi_rdata;
      bus_resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    check(bus_data, exp, what);
  endtask

  // two sync flops, result flop, event flop, status flop
  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask

  task automatic reset_values();
    logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24, 8'h44, 8'h64};
    check(irq, 1'b0, "irq at reset");
    check(pin_oe, 3'h0, "oe at reset");
    for (int k = 0; k < 8; k++) begin
      // reset control is level sense on a low result, so raw status sets at once
      rd_check(regs[k], (k == 1) ? 32'h7 : 32'h0, "reset value");
    end
    rd_check(8'h0C, 32'h0, "unmapped read");
    check(bus_resp, RESP_SLVERR, "unmapped read resp");
    wr(8'h0C, 32'hFFFF_FFFF);
    check(bus_resp, RESP_SLVERR, "unmapped write resp");
  endtask

  task automatic compare_pins();
    for (int ch = 0; ch < 3; ch++) begin
      wr(OFS_CHAN_CTRL + 8'(ch * 32), 32'h0);
      neg_mv[ch] <= 16'h03E8;
      settle();
      rd_check(OFS_CHAN_STATUS + 8'(ch * 32), 32'h2, "below gives one");
      check(vin_minus_route[ch], ROUTE_OWN_PIN, "minus route");
      neg_mv[ch] <= 16'h09C4;
      settle();
      rd_check(OFS_CHAN_STATUS + 8'(ch * 32), 32'h0, "above gives zero");
    end
  endtask

  task automatic sources();
    route_type exp_route;
    pos_mv <= '{16'h09C4, 16'h01F4, 16'h01F4};
    neg_mv <= '{16'h03E8, 16'h03E8, 16'h03E8};
    for (int ch = 0; ch < 3; ch++) begin
      for (int sel = 0; sel < 4; sel++) begin
        wr(OFS_CHAN_CTRL + 8'(ch * 32), 32'(sel) << 9);
        exp_route = (sel == 3) ? ROUTE_OPEN : (sel == 2) ? ROUTE_REFERENCE :
                    (sel == 1 && ch != 0) ? ROUTE_CHAN0_PIN : ROUTE_OWN_PIN;
        check(vin_plus_route[ch], exp_route, "plus route");
        if (sel < 3) begin
          settle();
          rd_check(OFS_CHAN_STATUS + 8'(ch * 32),
                   (sel == 1 || (sel == 0 && ch == 0)) ? 32'h2 : 32'h0, "routed result");
        end
      end
    end
  endtask

  task automatic ladder();
    logic [22:0] tbl [5] = '{{1'b1, 1'b0, 4'h5, 16'h0546, 1'b1},
                             {1'b1, 1'b1, 4'hF, 16'h0834, 1'b1},
                             {1'b1, 1'b0, 4'h0, 16'h0384, 1'b0},
                             {1'b1, 1'b1, 4'h9, 16'h0384, 1'b1},
                             {1'b0, 1'b1, 4'h9, 16'h0384, 1'b0}};
    logic en, ladder_range_select, exp_bit;
    logic [3:0] tap;
    logic [15:0] nv;
    wr(OFS_CHAN_CTRL, 32'h0000_0400);
    for (int k = 0; k < 5; k++) begin
      {en, ladder_range_select, tap, nv, exp_bit} = tbl[k];
      wr(OFS_REF_CTRL, {22'h0, en, ladder_range_select, 4'h0, tap});
      neg_mv[0] <= nv;
      check(ladder_drive, !en ? {2'b01, 4'h0, 5'h00, 5'h17} :
            {en, ladder_range_select, tap, ladder_range_select ? {1'b0, tap} : {1'b0, tap} + 5'h08, ladder_range_select ? 5'h17 : 5'h1F}, "ladder");
      settle();
      rd_check(OFS_CHAN_STATUS, {30'h0, exp_bit, 1'b0}, "reference compare");
    end
    wr(OFS_REF_CTRL, 32'h0);
  endtask

  // rise raises the interrupt, fall fires the trigger
  task automatic interrupts();
    wr(OFS_CHAN_CTRL, 32'h0000_0128);
    wr(OFS_CHAN_CTRL + 8'h20, 32'h0000_0608);
    wr(OFS_CHAN_CTRL + 8'h40, 32'h0000_0608);
    pos_mv[0] <= 16'h07D0;
    neg_mv[0] <= 16'h09C4;
    settle();
    wr(OFS_MASKED_STAT, 32'h7);
    trig_count = 0;
    neg_mv[0] <= 16'h03E8;
    settle();
    rd_check(OFS_RAW_STAT, 32'h1, "raw set on rise");
    rd_check(OFS_MASKED_STAT, 32'h0, "masked while disabled");
    check(irq, 1'b0, "irq masked");
    check(trig_count, 0, "no trigger on rise");
    wr(OFS_RAW_STAT, 32'h0);
    rd_check(OFS_RAW_STAT, 32'h1, "raw read only");
    wr(OFS_INT_ENABLE, 32'h1);
    check(irq, 1'b1, "irq enabled");
    rd_check(OFS_MASKED_STAT, 32'h1, "masked set");
    wr(OFS_MASKED_STAT, 32'h0);
    rd_check(OFS_RAW_STAT, 32'h1, "zero write no effect");
    wr(OFS_MASKED_STAT, 32'h1);
    rd_check(OFS_RAW_STAT, 32'h0, "one write clears");
    check(irq, 1'b0, "irq cleared");
    neg_mv[0] <= 16'h09C4;
    settle();
    check(trig_count, 1, "trigger on fall");
    rd_check(OFS_RAW_STAT, 32'h0, "no interrupt on fall");
  endtask

  task automatic shared_pin();
    wr(OFS_CHAN_CTRL + 8'h20, 32'h0000_0800);
    check(pin_oe[1], 1'b0, "shared pin sensing");
    wr(OFS_CHAN_CTRL + 8'h20, 32'h0000_0C00);
    check(pin_oe[1], 1'b1, "shared pin driving");
    wr(OFS_CHAN_CTRL, 32'h0000_0800);
    check(pin_oe[0], 1'b1, "channel 0 output");
  endtask

  initial begin
    pos_mv = '{16'h07D0, 16'h07D0, 16'h07D0};
    neg_mv = '{16'h09C4, 16'h09C4, 16'h09C4};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    compare_pins();
    sources();
    ladder();
    interrupts();
    shared_pin();
    tally_and_finish();
  end
endmodule // test_comparator_control

bind comparator_control comparator_monitor #(.N_CHAN(N_CHAN)) comparator_monitor_i (.*);
